// ---- hdl/byte_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps

module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Filling side.
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side.
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words.
    logic [AW-1:0]    wr_q, wr_d;      // Write index.
    logic [AW-1:0]    rd_q, rd_d;      // Read index.
    logic [AW:0]      cnt_q, cnt_d;    // Words held.
    logic             push, pop;

    // Full and empty come straight from the held count.
    assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // Next indices and count; push and pop may share a cycle.
    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    // Registers only; the storage word is written on a push.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_q[wr_q] <= in_data;
            end
        end
    end

endmodule

// ---- hdl/ep_buffer.sv ----
// Endpoint byte store: one write port and two read ports over all banks.
`timescale 1ns/100ps

`include "usb_ep_map.svh"

module ep_buffer (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Write port.
    input  wire logic                  wr_en,
    input  wire logic [`EP_ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]            wr_data,
    // Read port for the packet sender.
    input  wire logic [`EP_ADDR_W-1:0] snd_addr,
    output logic [7:0]                 snd_data,
    // Read port for firmware.
    input  wire logic [`EP_ADDR_W-1:0] fw_addr,
    output logic [7:0]                 fw_data
);

    localparam int WORDS = `EP_BANKS * `EP_BUF_DEPTH;

    logic [7:0] mem_q [WORDS];   // Byte storage, flip-flops.

    // Both read ports look at the stored bytes directly.
    assign snd_data = mem_q[snd_addr];
    assign fw_data  = mem_q[fw_addr];

    // Storage is cleared at reset so a stale read shows zero.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

endmodule

// ---- hdl/usb_ep_in_ctrl.sv ----
// Endpoint IN, OUT and control handshake logic for a full-speed device.
//
// Behaviour
// - Single buffer: NAK every IN until ready.
// - Ready with empty buffer sends zero-length packet.
// - Clearing ready discards the loaded packet.
// - Acknowledged IN sets done flag, interrupt.
// - Retries of unacknowledged IN handled internally.
// - Ping-pong: setting ready swaps firmware bank.
// - Ping-pong: NAK IN to bank not ready.
// - Ping-pong: done flag set per acknowledged bank.
// - Direction flag reads zero during setup.
// - Setup data on endpoint 0 sets setup flag, stored like OUT.
// - Setup flag clears other flags, raises interrupt.
// - Control full duplex, others one direction only.
// - Control IN data completion sets done flag.
// - Direction flag zero during status stages; the logic clears it only on setup, otherwise firmware writes it.
// - Status stage is opposite zero-length packet.
// - OUT sets bank0 flag; NAK until cleared.
// - Data port writes selected buffer, pointer advances.
// - Endpoint 0 is always the control endpoint.
`timescale 1ns/100ps

`include "usb_ep_map.svh"

module usb_ep_in_ctrl (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Firmware configuration.
    input  wire logic [2:0]            endpoint_select_reg,
    input  wire logic                  ep1_enable,
    input  wire logic [1:0]            endpoint_transfer_kind,
    input  wire logic                  ep1_dir_in,
    input  wire logic                  ep1_pingpong,
    input  wire logic                  irq_enable,
    // Firmware commands, one-cycle pulses on the selected endpoint.
    input  wire logic                  fw_set_tx_ready,
    input  wire logic                  fw_clr_tx_ready,
    input  wire logic                  fw_clr_tx_done,
    input  wire logic                  fw_clr_setup,
    input  wire logic                  fw_clr_out_bank0,
    input  wire logic                  fw_dir_write,
    input  wire logic                  fw_dir_value,
    input  wire logic                  fw_data_write,
    input  wire logic [7:0]            endpoint_data_port,
    input  wire logic                  fw_data_read,
    // Firmware status.
    output logic [7:0]                 fw_read_data,
    output logic [7:0]                 endpoint_status_reg,
    output logic [`EP_CNT_W-1:0]       byte_count,
    output logic                       usb_irq,
    // Tokens and received data from the serial engine.
    input  wire logic                  tok_valid,
    input  wire usb_ep_pkg::tok_pid_t  tok_pid,
    input  wire logic [2:0]            tok_ep,
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_data,
    input  wire logic                  rx_end,
    input  wire logic                  rx_crc_ok,
    input  wire logic                  host_ack,
    input  wire logic                  host_timeout,
    // Answers to the serial engine.
    output logic                       hs_valid,
    output usb_ep_pkg::hs_kind_t       hs_kind,
    output logic                       pkt_start,
    output logic                       pkt_data1,
    output logic                       pkt_zlp,
    output logic                       tx_valid,
    output logic [7:0]                 tx_data,
    output logic                       tx_last,
    input  wire logic                  tx_ready
);

    // Bank index of an endpoint: endpoint 0 owns bank 0 only.
    function automatic logic [1:0] bank_id(input logic ep, input logic bk);
        bank_id = ep ? (bk ? 2'h2 : 2'h1) : 2'h0;
    endfunction

    // Buffer address from a bank index and a byte pointer.
    function automatic logic [`EP_ADDR_W-1:0] buf_addr(
        input logic [1:0] bid, input logic [`EP_PTR_W-1:0] ptr);
        buf_addr = {bid, ptr};
    endfunction

    // Per-endpoint flags, indexed by endpoint (0 or 1); setup and direction are endpoint 0 only.
    logic [1:0][1:0]        rdy_q, rdy_d;        // Ready per bank.
    logic [1:0]             done_q, done_d;      // Transmit done.
    logic [1:0]             outb0_q, outb0_d;    // OUT bank 0 received.
    logic                   setup_q, setup_d;    // Setup received.
    logic                   dir_q, dir_d;        // Control direction.
    logic [1:0]             tog_q, tog_d;        // IN data toggle.
    logic [1:0]             fwbk_q, fwbk_d;      // Bank firmware fills.
    logic [1:0]             sndbk_q, sndbk_d;    // Bank sent next.
    logic [2:0][`EP_CNT_W-1:0] wcnt_q, wcnt_d;   // Bytes loaded per bank.
    logic [1:0][`EP_CNT_W-1:0] rcnt_q, rcnt_d;   // Bytes received.
    // Transaction and sender state.
    usb_ep_pkg::snd_state_t st_q, st_d;
    logic                   cur_q, cur_d;        // Endpoint in flight.
    logic [`EP_PTR_W-1:0]   idx_q, idx_d;        // Sender byte index.
    logic                   oact_q, oact_d;      // OUT data phase open.
    logic                   oacc_q, oacc_d;      // OUT data phase kept.
    logic                   osetup_q, osetup_d;  // Phase began with SETUP.
    logic [`EP_CNT_W-1:0]   ocnt_q, ocnt_d;      // Bytes seen this phase.
    logic [`EP_PTR_W-1:0]   frd_q, frd_d;        // Firmware read pointer.
    // Registered outputs.
    logic                   hsv_q, hsv_d;
    usb_ep_pkg::hs_kind_t   hsk_q, hsk_d;
    logic                   pst_q, pst_d, pd1_q, pd1_d, pz_q, pz_d;
    logic [7:0]             frdat_q, frdat_d, stat_q, stat_d;
    logic [`EP_CNT_W-1:0]   bc_q, bc_d;
    logic                   irq_q, irq_d;
    // Buffer and FIFO wiring.
    logic                   bwe;
    logic [`EP_ADDR_W-1:0]  bwa, bsa, bfa;
    logic [7:0]             bwd, bsd, bfd;
    logic                   fin_valid, fin_ready;
    logic [8:0]             fout;
    // Decoded selections.
    logic                   sel, sel_ok, tep, tep_ok, duplex, last;
    logic [1:0]             sbid;

    ep_buffer u_buf (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .wr_en    (bwe),
        .wr_addr  (bwa),
        .wr_data  (bwd),
        .snd_addr (bsa),
        .snd_data (bsd),
        .fw_addr  (bfa),
        .fw_data  (bfd)
    );

    // The FIFO decouples the buffer from the serial engine's pace.
    byte_fifo #(.WIDTH(9), .DEPTH(`TX_FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (fin_valid),
        .in_data   ({last, bsd}),
        .in_ready  (fin_ready),
        .out_valid (tx_valid),
        .out_data  (fout),
        .out_ready (tx_ready)
    );
    assign tx_last = fout[8];
    assign tx_data = fout[7:0];

    // Selection decode; endpoint 0 is control whatever the kind input.
    always_comb begin
        sel    = endpoint_select_reg[0];
        sel_ok = (endpoint_select_reg == 3'h0) ||
                 (endpoint_select_reg == 3'h1 && ep1_enable);
        tep    = tok_ep[0];
        tep_ok = (tok_ep == 3'h0) || (tok_ep == 3'h1 && ep1_enable);
        duplex = (tok_ep == 3'h0) ||
                 (endpoint_transfer_kind == `KIND_CONTROL);
        sbid   = bank_id(cur_q, sndbk_q[cur_q]);
        last   = (6'(idx_q) + 6'h01 == wcnt_q[sbid]);
        bsa    = buf_addr(sbid, idx_q);
        bfa    = buf_addr(bank_id(sel, 1'b0), frd_q);
        fin_valid = (st_q == usb_ep_pkg::SND_PUSH);
    end

    // All flag, counter and handshake updates. Firmware clears come
    // first so that a hardware set in the same cycle wins.
    always_comb begin
        rdy_d = rdy_q;     done_d = done_q;   outb0_d = outb0_q;
        setup_d = setup_q; dir_d = dir_q;     tog_d = tog_q;
        fwbk_d = fwbk_q;   sndbk_d = sndbk_q; wcnt_d = wcnt_q;
        rcnt_d = rcnt_q;   st_d = st_q;       cur_d = cur_q;
        idx_d = idx_q;     oact_d = oact_q;   oacc_d = oacc_q;
        osetup_d = osetup_q; ocnt_d = ocnt_q; frd_d = frd_q;
        hsv_d = 1'b0;      hsk_d = hsk_q;     pst_d = 1'b0;
        pd1_d = pd1_q;     pz_d = pz_q;       frdat_d = frdat_q;
        bwe = 1'b0;        bwa = '0;          bwd = 8'h00;

        // Firmware commands on the selected endpoint.
        if (sel_ok) begin
            if (fw_clr_tx_done) begin
                done_d[sel] = 1'b0;
            end
            // Cancelling drops the packet last marked ready.
            if (fw_clr_tx_ready) begin
                if (sel && ep1_pingpong) begin
                    rdy_d[1][~fwbk_q[1]] = 1'b0;
                    wcnt_d[bank_id(1'b1, ~fwbk_q[1])] = '0;
                    fwbk_d[1] = ~fwbk_q[1];
                end else begin
                    rdy_d[sel][0] = 1'b0;
                    wcnt_d[bank_id(sel, 1'b0)] = '0;
                end
            end
            // Marking ready swaps the filling bank in ping-pong.
            if (fw_set_tx_ready) begin
                rdy_d[sel][fwbk_q[sel]] = 1'b1;
                if (sel && ep1_pingpong) begin
                    fwbk_d[1] = ~fwbk_q[1];
                end
            end
            // Clearing a receive flag frees the buffer for reuse.
            if (fw_clr_out_bank0) begin
                outb0_d[sel] = 1'b0;
                rcnt_d[sel] = '0;
                frd_d = '0;
            end
            if (fw_clr_setup && !sel) begin
                setup_d = 1'b0;
                rcnt_d[0] = '0;
                frd_d = '0;
            end
            if (fw_dir_write && !sel) begin
                dir_d = fw_dir_value;
            end
            if (fw_data_read) begin
                frdat_d = bfd;
                frd_d = `EP_PTR_W'(frd_q + 1'b1);
            end
            // Data port write lands at the fill pointer of the bank.
            if (fw_data_write &&
                wcnt_q[bank_id(sel, fwbk_q[sel])] < `EP_CNT_W'(`EP_BUF_DEPTH)
                && !(oact_q && oacc_q && rx_valid)) begin
                bwe = 1'b1;
                bwa = buf_addr(bank_id(sel, fwbk_q[sel]),
                    wcnt_q[bank_id(sel, fwbk_q[sel])][`EP_PTR_W-1:0]);
                bwd = endpoint_data_port;
                wcnt_d[bank_id(sel, fwbk_q[sel])] =
                    `EP_CNT_W'(wcnt_q[bank_id(sel, fwbk_q[sel])] + 1'b1);
            end
        end

        // Tokens are taken only while no IN packet is in flight.
        if (tok_valid && tep_ok && st_q == usb_ep_pkg::SND_IDLE) begin
            cur_d = tep;
            if (tok_pid == usb_ep_pkg::PID_IN) begin
                if (!duplex && !ep1_dir_in) begin
                    // Wrong direction for a one-way endpoint: no answer.
                    cur_d = cur_q;
                end else if (rdy_q[tep][sndbk_q[tep]]) begin
                    pst_d = 1'b1;
                    pd1_d = tog_q[tep];
                    pz_d  = (wcnt_q[bank_id(tep, sndbk_q[tep])] == '0);
                    idx_d = '0;
                    st_d  = pz_d ? usb_ep_pkg::SND_WAIT
                                 : usb_ep_pkg::SND_PUSH;
                end else begin
                    hsv_d = 1'b1;
                    hsk_d = usb_ep_pkg::HS_NAK;
                end
            end else if (duplex || !ep1_dir_in) begin
                // OUT or SETUP: a setup to endpoint 0 is always kept, anything else only if free.
                oact_d   = 1'b1;
                osetup_d = (tok_pid == usb_ep_pkg::PID_SETUP) && !tep;
                oacc_d   = osetup_d || !outb0_q[tep];
                ocnt_d   = '0;
            end
        end

        // OUT bytes are stored until the bank is full; extra is counted.
        if (oact_q && rx_valid) begin
            if (ocnt_q != `CNT_MAX) begin
                ocnt_d = `EP_CNT_W'(ocnt_q + 1'b1);
            end
            if (oacc_q && ocnt_q < `EP_CNT_W'(`EP_BUF_DEPTH)) begin
                bwe = 1'b1;
                bwa = buf_addr(bank_id(cur_q, 1'b0), ocnt_q[`EP_PTR_W-1:0]);
                bwd = rx_data;
            end
        end

        // End of an OUT phase: a bad CRC gets no answer at all.
        if (oact_q && rx_end) begin
            oact_d = 1'b0;
            if (rx_crc_ok) begin
                hsv_d = 1'b1;
                hsk_d = oacc_q ? usb_ep_pkg::HS_ACK : usb_ep_pkg::HS_NAK;
                if (oacc_q) begin
                    rcnt_d[cur_q] = ocnt_q;
                    frd_d = '0;
                    if (osetup_q) begin
                        setup_d = 1'b1;
                        outb0_d[0] = 1'b0;
                        done_d[0]  = 1'b0;
                        rdy_d[0]   = 2'b00;
                        wcnt_d[0]  = '0;
                        dir_d      = 1'b0;
                        tog_d[0]   = 1'b1;
                    end else begin
                        outb0_d[cur_q] = 1'b1;
                    end
                end
            end
        end

        // Sender: copy the bank into the FIFO, then wait for the host.
        case (st_q)
            usb_ep_pkg::SND_IDLE: begin
            end
            usb_ep_pkg::SND_PUSH: begin
                if (fin_ready) begin
                    idx_d = `EP_PTR_W'(idx_q + 1'b1);
                    if (last) begin
                        st_d = usb_ep_pkg::SND_WAIT;
                    end
                end
            end
            usb_ep_pkg::SND_WAIT: begin
                if (host_ack) begin
                    // Completion frees the bank and flips the toggle.
                    done_d[cur_q] = 1'b1;
                    rdy_d[cur_q][sndbk_q[cur_q]] = 1'b0;
                    wcnt_d[sbid] = '0;
                    tog_d[cur_q] = ~tog_q[cur_q];
                    if (cur_q && ep1_pingpong) begin
                        sndbk_d[1] = ~sndbk_q[1];
                    end
                    st_d = usb_ep_pkg::SND_IDLE;
                end else if (host_timeout) begin
                    // Bank kept intact; the next IN resends it.
                    st_d = usb_ep_pkg::SND_IDLE;
                end
            end
            default: begin
                st_d = usb_ep_pkg::SND_IDLE;
            end
        endcase
    end

    // Status word of the selected endpoint; interrupt from the flags of both endpoints.
    always_comb begin
        stat_d = 8'h00;
        bc_d   = '0;
        if (sel_ok) begin
            stat_d[`ST_TX_DONE]   = done_q[sel];
            stat_d[`ST_OUT_BANK0] = outb0_q[sel];
            stat_d[`ST_SETUP]     = !sel && setup_q;
            stat_d[`ST_TX_READY]  = rdy_q[sel][fwbk_q[sel]];
            stat_d[`ST_DIR]       = !sel && dir_q;
            bc_d = rcnt_q[sel];
        end
        irq_d = irq_enable &&
                (|done_q || |outb0_q || setup_q);
    end

    // State registers.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdy_q <= '0;   done_q <= '0;  outb0_q <= '0;
            setup_q <= 1'b0; dir_q <= 1'b0; tog_q <= '0;
            fwbk_q <= '0;  sndbk_q <= '0; wcnt_q <= '0;
            rcnt_q <= '0;  st_q <= usb_ep_pkg::SND_IDLE;
            cur_q <= 1'b0; idx_q <= '0;   oact_q <= 1'b0;
            oacc_q <= 1'b0; osetup_q <= 1'b0; ocnt_q <= '0;
            frd_q <= '0;   hsv_q <= 1'b0; hsk_q <= usb_ep_pkg::HS_ACK;
            pst_q <= 1'b0; pd1_q <= 1'b0; pz_q <= 1'b0;
            frdat_q <= 8'h00; stat_q <= 8'h00; bc_q <= '0;
            irq_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;   done_q <= done_d; outb0_q <= outb0_d;
            setup_q <= setup_d; dir_q <= dir_d; tog_q <= tog_d;
            fwbk_q <= fwbk_d; sndbk_q <= sndbk_d; wcnt_q <= wcnt_d;
            rcnt_q <= rcnt_d; st_q <= st_d;     cur_q <= cur_d;
            idx_q <= idx_d;   oact_q <= oact_d; oacc_q <= oacc_d;
            osetup_q <= osetup_d; ocnt_q <= ocnt_d; frd_q <= frd_d;
            hsv_q <= hsv_d;   hsk_q <= hsk_d;   pst_q <= pst_d;
            pd1_q <= pd1_d;   pz_q <= pz_d;     frdat_q <= frdat_d;
            stat_q <= stat_d; bc_q <= bc_d;     irq_q <= irq_d;
        end
    end

    // Outputs straight from their registers.
    assign hs_valid            = hsv_q;
    assign hs_kind             = hsk_q;
    assign pkt_start           = pst_q;
    assign pkt_data1           = pd1_q;
    assign pkt_zlp             = pz_q;
    assign fw_read_data        = frdat_q;
    assign endpoint_status_reg = stat_q;
    assign byte_count          = bc_q;
    assign usb_irq             = irq_q;

endmodule

// ---- shared/usb_ep_map.svh ----
// Field positions, sizes and encodings of the endpoint block.
`ifndef USB_EP_MAP_SVH
`define USB_EP_MAP_SVH

// Bit positions inside the endpoint status word.
`define ST_TX_DONE      0
`define ST_OUT_BANK0    1
`define ST_SETUP        2
`define ST_TX_READY     4
`define ST_OUT_BANK1    6
`define ST_DIR          7

// Byte buffer geometry: three banks of 32 bytes each.
`define EP_BUF_DEPTH    32
`define EP_PTR_W        5
`define EP_CNT_W        6
`define EP_BANKS        3
`define EP_ADDR_W       7

// Transfer kind encodings for the configurable endpoint.
`define KIND_CONTROL    2'h0
`define KIND_ISO        2'h1
`define KIND_BULK       2'h2
`define KIND_INTR       2'h3

// Transmit FIFO depth and the largest byte count that is kept.
`define TX_FIFO_DEPTH   8
`define CNT_MAX         6'h3F

`endif

// ---- shared/usb_ep_pkg.sv ----
// Types shared by the endpoint transaction logic and its neighbours.
package usb_ep_pkg;

    // Token kinds delivered by the serial engine.
    typedef enum logic [1:0] {
        PID_IN,
        PID_OUT,
        PID_SETUP
    } tok_pid_t;

    // Handshake answers sent back to the host.
    typedef enum logic {
        HS_ACK,
        HS_NAK
    } hs_kind_t;

    // States of the IN packet sender.
    typedef enum logic [1:0] {
        SND_IDLE,
        SND_PUSH,
        SND_WAIT
    } snd_state_t;

endpackage

// ---- sim/test_usb_ep_in_ctrl.sv ----
// Bench for the endpoint handshake block.
`timescale 1ns/100ps
module test_usb_ep_in_ctrl;
    logic ref_clk = 0, resetn = 0, tok_valid = 0, rx_valid = 0, rx_end = 0;
    logic fw_data_write = 0, stall = 0, fail = 0, irq_enable = 1;
    logic [7:0] cmd = '0;
    logic [2:0] endpoint_select_reg = '0, tok_ep = '0;
    logic [7:0] endpoint_data_port = '0, endpoint_status_reg, nbytes;
    logic [5:0] byte_count;
    logic usb_irq, hs_valid, pkt_start, pkt_data1, pkt_zlp, tx_valid;
    logic tx_last, tx_ready, host_ack, host_timeout, ep1_enable = 0;
    usb_ep_pkg::tok_pid_t tok_pid = usb_ep_pkg::PID_IN;
    usb_ep_pkg::hs_kind_t hs_kind;
    int n_mismatch = 0, checks_done = 0;
    usb_ep_in_ctrl u_dut (.*, .endpoint_transfer_kind(2'h2),
        .ep1_dir_in(1'h1), .ep1_pingpong(1'h0),
        .fw_set_tx_ready(cmd[4]), .fw_clr_tx_ready(cmd[3]),
        .fw_clr_tx_done(cmd[2]), .fw_clr_setup(cmd[1]),
        .fw_clr_out_bank0(cmd[0]), .fw_dir_write(cmd[5]),
        .fw_dir_value(cmd[6]), .fw_data_read(cmd[7]), .fw_read_data(),
        .rx_data(8'h5A), .rx_crc_ok(1'h1), .tx_data());
    usb_host_model u_host (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [8:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic pulse(input logic [7:0] c);
        @(posedge ref_clk) cmd <= c;
        @(posedge ref_clk) cmd <= '0;
    endtask
    task automatic tok(input usb_ep_pkg::tok_pid_t p);
        @(posedge ref_clk) tok_pid <= p;
        tok_valid <= 1'h1;
        @(posedge ref_clk) tok_valid <= 1'h0;
        #1;
    endtask
    task automatic wrn(input int n);
        @(posedge ref_clk) fw_data_write <= 1'h1;
        for (int i = 0; i < n; i++) begin
            endpoint_data_port <= 8'(i);
            @(posedge ref_clk);
        end
        fw_data_write <= 1'h0;
    endtask
    task automatic rxp(input int n);
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'h1;
            @(posedge ref_clk);
        end
        rx_valid <= 1'h0;
        rx_end <= 1'h1;
        @(posedge ref_clk) rx_end <= 1'h0;
        #1;
    endtask
    task automatic ackw;
        for (int i = 0; i < 99 && !(host_ack || host_timeout); i++)
            @(negedge ref_clk);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'h1;
        tok(usb_ep_pkg::PID_IN);
        chk("nak", {hs_valid, hs_kind}, 9'h003);
        tok(usb_ep_pkg::PID_SETUP);
        rxp(8);
        chk("setup ack", {hs_valid, hs_kind}, 9'h002);
        @(posedge ref_clk) #1;
        chk("setup", {usb_irq, endpoint_status_reg}, 9'h104);
        chk("count", {3'h0, byte_count}, 9'h008);
        pulse(5'h02);
        pulse(5'h10);
        tok(usb_ep_pkg::PID_IN);
        chk("zlp", {pkt_start, pkt_zlp, pkt_data1}, 9'h007);
        ackw;
        chk("done", {usb_irq, endpoint_status_reg}, 9'h101);
        pulse(5'h04);
        wrn(3);
        pulse(5'h10);
        pulse(5'h08);
        tok(usb_ep_pkg::PID_IN);
        chk("cancel", {hs_valid, hs_kind}, 9'h003);
        @(posedge ref_clk) {stall, fail} <= 2'h3;
        pulse(8'h60);
        wrn(10);
        pulse(5'h10);
        tok(usb_ep_pkg::PID_IN);
        chk("send", {pkt_start, pkt_zlp, pkt_data1}, 9'h004);
        repeat (20) @(negedge ref_clk);
        chk("held", {endpoint_status_reg, tx_valid}, 9'h121);
        @(posedge ref_clk) stall <= 1'h0;
        ackw;
        @(posedge ref_clk) {fail, irq_enable} <= 2'h0;
        tok(usb_ep_pkg::PID_IN);
        chk("retry", {pkt_start, pkt_zlp, pkt_data1}, 9'h004);
        ackw;
        chk("bytes", {1'h0, nbytes}, 9'h014);
        pulse(8'h24);
        tok(usb_ep_pkg::PID_OUT);
        rxp(0);
        chk("out ack", {hs_valid, hs_kind}, 9'h002);
        tok(usb_ep_pkg::PID_OUT);
        rxp(2);
        chk("out nak", {hs_valid, hs_kind}, 9'h003);
        @(posedge ref_clk) #1;
        chk("out", {usb_irq, endpoint_status_reg}, 9'h002);
        end_sim;
    end
endmodule

// ---- sim/usb_ep_in_ctrl_monitor.sv ----
// Port checks for the endpoint handshake block.
`timescale 1ns/100ps
module usb_ep_in_ctrl_monitor (
    input wire logic                 ref_clk,
    input wire logic                 resetn,
    input wire logic                 irq_enable,
    input wire logic                 tok_valid,
    input wire usb_ep_pkg::tok_pid_t tok_pid,
    input wire logic                 rx_end,
    input wire logic                 host_ack,
    input wire logic                 hs_valid,
    input wire usb_ep_pkg::hs_kind_t hs_kind,
    input wire logic                 pkt_start,
    input wire logic                 pkt_zlp,
    input wire logic [7:0]           endpoint_status_reg,
    input wire logic                 usb_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_irq_gate: assert property (!irq_enable |=> !usb_irq)
        else $error("irq without enable");
    chk_flag_irq: assert property (|endpoint_status_reg[2:0]
        && $past(irq_enable) |-> usb_irq) else $error("flag without irq");
    chk_one_answer: assert property (!(pkt_start && hs_valid))
        else $error("two answers");
    chk_start_cause: assert property (pkt_start
        |-> $past(tok_valid && tok_pid == usb_ep_pkg::PID_IN))
        else $error("start without token");
    chk_hs_cause: assert property (hs_valid
        |-> $past(tok_valid) || $past(rx_end)) else $error("stray handshake");
    chk_start_pulse: assert property (pkt_start |=> !pkt_start)
        else $error("start held");
    chk_ack_done: assert property (host_ack
        |-> ##2 endpoint_status_reg[0]) else $error("done missing");
    chk_setup_clear: assert property ($rose(endpoint_status_reg[2])
        |-> (endpoint_status_reg & 8'hFB) == 8'h00) else $error("flags kept");
    cover property (pkt_start && pkt_zlp);
    cover property (hs_valid && hs_kind == usb_ep_pkg::HS_NAK);
    cover property ($rose(endpoint_status_reg[2]));
endmodule
bind usb_ep_in_ctrl usb_ep_in_ctrl_monitor u_mon (.*);

// ---- sim/usb_host_model.sv ----
// Host model: drains packet bytes, then acknowledges or, when fail is set, raises host_timeout.
`timescale 1ns/100ps
module usb_host_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic stall,
    input wire logic fail,
    input wire logic pkt_start,
    input wire logic pkt_zlp,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic     tx_ready,
    output logic     host_ack,
    output logic     host_timeout,
    output logic [7:0] nbytes
);
    logic fin;
    assign tx_ready = !stall;
    // A packet ends on its last byte, or at once when it is empty.
    assign fin = (tx_valid && tx_ready && tx_last) || (pkt_start && pkt_zlp);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {host_ack, host_timeout, nbytes} <= '0;
        end else begin
            host_ack     <= fin && !fail;
            host_timeout <= fin && fail;
            nbytes       <= nbytes + 8'(tx_valid && tx_ready);
        end
    end
endmodule
